// ### core/hrv_defs.svh
// Purpose: Constants for hold-off and revalidation timing
// Assumes: Single VCXO clock domain, 125 MHz
// Notes:   Offsets are not used; settings arrive on write strobes
`ifndef HRV_DEFS_SVH
`define HRV_DEFS_SVH

// Reset values of the settings
`define HRV_TBSEL_RST    2'h2
`define HRV_CNTSEL_RST   2'h2
`define HRV_PERIOD_RST   8'h80

// Prescaler width and wrap masks for 2^15, 2^16, 2^17
`define HRV_PRE_W        17
`define HRV_MASK_DIV15   17'h07fff
`define HRV_MASK_DIV16   17'h0ffff
`define HRV_MASK_DIV17   17'h1ffff

// Required valid periods per count code
`define HRV_REVAL_W      7
`define HRV_REVAL_2      7'h02
`define HRV_REVAL_16     7'h10
`define HRV_REVAL_32     7'h20
`define HRV_REVAL_64     7'h40

`endif

// ### core/hrv_pkg.sv
// Purpose: Types and decode functions for hold-off and revalidation
// Assumes: hrv_defs.svh on the include path
// Notes:   The top uses the mask decoder; the per-input unit uses the count decoder
`include "hrv_defs.svh"

package hrv_pkg;

  // Hold-off timebase codes; code 3 is undefined and acts as 2^17
  typedef enum logic [1:0] {
    HRV_TB_DIV15 = 2'h0,
    HRV_TB_DIV16 = 2'h1,
    HRV_TB_DIV17 = 2'h2,
    HRV_TB_RSVD  = 2'h3
  } hrv_tbsel_t;

  // Revalidation count codes
  typedef enum logic [1:0] {
    HRV_CS_2  = 2'h0,
    HRV_CS_16 = 2'h1,
    HRV_CS_32 = 2'h2,
    HRV_CS_64 = 2'h3
  } hrv_cntsel_t;

  // Hold-off sequencer states
  typedef enum logic {
    HRV_HO_IDLE  = 1'b0,
    HRV_HO_COUNT = 1'b1
  } hrv_hostate_t;

  // Prescaler wrap mask for a timebase code
  function automatic logic [`HRV_PRE_W-1:0] hrv_tick_mask(hrv_tbsel_t s);
    unique case (s)
      HRV_TB_DIV15: hrv_tick_mask = `HRV_MASK_DIV15;
      HRV_TB_DIV16: hrv_tick_mask = `HRV_MASK_DIV16;
      HRV_TB_DIV17: hrv_tick_mask = `HRV_MASK_DIV17;
      HRV_TB_RSVD:  hrv_tick_mask = `HRV_MASK_DIV17;
    endcase
  endfunction : hrv_tick_mask

  // Required valid periods for a count code
  function automatic logic [`HRV_REVAL_W-1:0] hrv_reval_len(hrv_cntsel_t s);
    unique case (s)
      HRV_CS_2:  hrv_reval_len = `HRV_REVAL_2;
      HRV_CS_16: hrv_reval_len = `HRV_REVAL_16;
      HRV_CS_32: hrv_reval_len = `HRV_REVAL_32;
      HRV_CS_64: hrv_reval_len = `HRV_REVAL_64;
    endcase
  endfunction : hrv_reval_len

endpackage : hrv_pkg

// ### core/hrv_reval_unit.sv
// Purpose: Revalidation counter and signal-loss flag for one input
// Assumes: Period events are one-cycle pulses synchronous to clk
// Notes:   A miss wins over a valid period in the same cycle
`timescale 1ns/1ns
`default_nettype none
`include "hrv_defs.svh"

module hrv_reval_unit (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  // Setting
  input  wire hrv_pkg::hrv_cntsel_t     countSel,
  // Input events
  input  wire logic                     lossEvent,
  input  wire logic                     validPeriod,
  input  wire logic                     missedPeriod,
  // Status
  output var  logic                     signalLossFlag,
  output var  logic [`HRV_REVAL_W-1:0]  revalCount
);
  import hrv_pkg::*;

  logic [`HRV_REVAL_W-1:0] cnt_q;
  logic                    flag_q;

  // Counter: a new loss always wins, so a loss in the zero cycle keeps flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (lossEvent) begin
      cnt_q <= hrv_reval_len(countSel);
    end else if (flag_q && missedPeriod) begin
      cnt_q <= hrv_reval_len(countSel);
    end else if (flag_q && validPeriod && cnt_q != '0) begin
      cnt_q <= cnt_q - `HRV_REVAL_W'(1);
    end
  end

  // Flag: set on loss, cleared as the count steps from one to zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= 1'b0;
    end else if (lossEvent) begin
      flag_q <= 1'b1;
    end else if (flag_q && !missedPeriod && validPeriod
                 && cnt_q == `HRV_REVAL_W'(1)) begin
      flag_q <= 1'b0;
    end
  end

  assign signalLossFlag = flag_q;
  assign revalCount     = cnt_q;

  property p_load;
    @(posedge clk) disable iff (!arst_n)
    lossEvent |=> flag_q && cnt_q == hrv_reval_len($past(countSel));
  endproperty
  a_load: assert property (p_load) else $error("load on loss wrong");

  property p_dec;
    @(posedge clk) disable iff (!arst_n)
    flag_q && !lossEvent && !missedPeriod && validPeriod
      && cnt_q > `HRV_REVAL_W'(1)
      |=> flag_q && cnt_q == $past(cnt_q) - `HRV_REVAL_W'(1);
  endproperty
  a_dec: assert property (p_dec) else $error("no decrement");

  property p_reload;
    @(posedge clk) disable iff (!arst_n)
    flag_q && !lossEvent && missedPeriod
      |=> cnt_q == hrv_reval_len($past(countSel));
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on miss");

  property p_clear;
    @(posedge clk) disable iff (!arst_n)
    flag_q && !lossEvent && !missedPeriod && validPeriod
      && cnt_q == `HRV_REVAL_W'(1) |=> !flag_q && cnt_q == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_min;
    @(posedge clk) disable iff (!arst_n)
    $rose(flag_q) |-> cnt_q >= `HRV_REVAL_2;
  endproperty
  a_min: assert property (p_min) else $error("count below minimum");

endmodule : hrv_reval_unit
`default_nettype wire

// ### core/hrv_holdoff_reval.sv
// Purpose: Hold-off prescaler, hold-off counter and input revalidation
// Assumes: clk is the VCXO clock; events are clk-synchronous pulses
// Notes:   Settings are written by strobe with one shared data byte
`timescale 1ns/1ns
`default_nettype none
`include "hrv_defs.svh"

module hrv_holdoff_reval (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  // Setting writes
  input  wire logic                        wrTimebaseSel,
  input  wire logic                        wrCountSel,
  input  wire logic                        wrPeriodCount,
  input  wire logic [7:0]                  wrData,
  // Setting readback
  output var  hrv_pkg::hrv_tbsel_t         holdoffTimebaseSelect,
  output var  hrv_pkg::hrv_cntsel_t        revalidationCountSelect,
  output var  logic [7:0]                  holdoffPeriodCount,
  // Reference input events, one bit per input
  input  wire logic [1:0]                  lossEvent,
  input  wire logic [1:0]                  validPeriod,
  input  wire logic [1:0]                  missedPeriod,
  // Revalidation status
  output var  logic [1:0]                  signalLossFlag,
  output var  logic [1:0][`HRV_REVAL_W-1:0] revalCount,
  // Hold-off status
  output var  logic                        holdoffTick,
  output var  logic                        holdoffActive,
  output var  logic [7:0]                  holdoffCount,
  output var  logic                        failoverSwitch
);
  import hrv_pkg::*;

  hrv_tbsel_t              tbSel_q;
  hrv_cntsel_t             cntSel_q;
  logic [7:0]              period_q;
  logic [`HRV_PRE_W-1:0]   pre_q;
  logic [`HRV_PRE_W-1:0]   tickMask;
  logic                    tick_q;
  hrv_hostate_t            hoState_q;
  logic [7:0]              hoCnt_q;
  logic                    failover_q;

  // Settings; the timebase defaults to 2^17 and the count to 32
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tbSel_q  <= hrv_tbsel_t'(`HRV_TBSEL_RST);
      cntSel_q <= hrv_cntsel_t'(`HRV_CNTSEL_RST);
      period_q <= `HRV_PERIOD_RST;
    end else begin
      if (wrTimebaseSel) begin
        tbSel_q <= hrv_tbsel_t'(wrData[1:0]);
      end
      if (wrCountSel) begin
        cntSel_q <= hrv_cntsel_t'(wrData[1:0]);
      end
      if (wrPeriodCount) begin
        period_q <= wrData;
      end
    end
  end

  // Free-running prescaler; never cleared so ticks stay evenly spaced
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + `HRV_PRE_W'(1);
    end
  end

  // Wrap detect on the selected low bits gives one pulse per 2^N cycles
  assign tickMask = hrv_tick_mask(tbSel_q);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= (pre_q & tickMask) == tickMask;
    end
  end

  // Sequencer runs while any input is still failed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hoState_q <= HRV_HO_IDLE;
    end else begin
      unique case (hoState_q)
        HRV_HO_IDLE: begin
          if (|lossEvent) begin
            hoState_q <= HRV_HO_COUNT;
          end
        end
        HRV_HO_COUNT: begin
          if (signalLossFlag == 2'h0 && lossEvent == 2'h0) begin
            hoState_q <= HRV_HO_IDLE;
          end
        end
      endcase
    end
  end

  // Hold-off counter; a zero setting fails over on every tick
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hoCnt_q    <= `HRV_PERIOD_RST;
      failover_q <= 1'b0;
    end else begin
      failover_q <= 1'b0;
      if (hoState_q == HRV_HO_IDLE) begin
        hoCnt_q <= period_q;
      end else if (tick_q) begin
        if (hoCnt_q <= 8'h01) begin
          failover_q <= 1'b1;
          hoCnt_q    <= period_q;
        end else begin
          hoCnt_q <= hoCnt_q - 8'h01;
        end
      end
    end
  end

  // One revalidation unit per reference input
  for (genvar i = 0; i < 2; i++) begin : gInput
    hrv_reval_unit uUnit (
      .clk            (clk),
      .arst_n         (arst_n),
      .countSel       (cntSel_q),
      .lossEvent      (lossEvent[i]),
      .validPeriod    (validPeriod[i]),
      .missedPeriod   (missedPeriod[i]),
      .signalLossFlag (signalLossFlag[i]),
      .revalCount     (revalCount[i])
    );
  end

  assign holdoffTimebaseSelect   = tbSel_q;
  assign revalidationCountSelect = cntSel_q;
  assign holdoffPeriodCount      = period_q;
  assign holdoffTick             = tick_q;
  assign holdoffActive           = (hoState_q == HRV_HO_COUNT);
  assign holdoffCount            = hoCnt_q;
  assign failoverSwitch          = failover_q;

  // Helper: cycles since last tick, valid only with a steady timebase
  logic [`HRV_PRE_W:0] gap_q;
  logic                gapOk_q;
  hrv_tbsel_t          tbSelDly_q;

  // Delayed select; a tick launched under the old mask must not arm the check
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tbSelDly_q <= hrv_tbsel_t'(`HRV_TBSEL_RST);
    end else begin
      tbSelDly_q <= tbSel_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_q   <= '0;
      gapOk_q <= 1'b0;
    end else begin
      gap_q   <= tick_q ? (`HRV_PRE_W+1)'(1) : gap_q + (`HRV_PRE_W+1)'(1);
      gapOk_q <= (wrTimebaseSel || tbSel_q != tbSelDly_q) ? 1'b0
                 : (tick_q ? 1'b1 : gapOk_q);
    end
  end

  property p_tick_period;
    @(posedge clk) disable iff (!arst_n)
    tick_q && gapOk_q && !wrTimebaseSel && !$past(wrTimebaseSel)
      |-> gap_q == {1'b0, tickMask} + (`HRV_PRE_W+1)'(1);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick spacing");

  property p_tick_pulse;
    @(posedge clk) disable iff (!arst_n)
    tick_q |=> !tick_q [*8];
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");

  property p_ho_start;
    @(posedge clk) disable iff (!arst_n)
    hoState_q == HRV_HO_IDLE && |lossEvent
      |=> hoState_q == HRV_HO_COUNT && hoCnt_q == $past(period_q);
  endproperty
  a_ho_start: assert property (p_ho_start) else $error("no hold-off start");

  property p_ho_dec;
    @(posedge clk) disable iff (!arst_n)
    hoState_q == HRV_HO_COUNT && tick_q && hoCnt_q > 8'h01
      |=> hoCnt_q == $past(hoCnt_q) - 8'h01 && !failover_q;
  endproperty
  a_ho_dec: assert property (p_ho_dec) else $error("no hold-off step");

  property p_ho_expire;
    @(posedge clk) disable iff (!arst_n)
    hoState_q == HRV_HO_COUNT && tick_q && hoCnt_q <= 8'h01
      |=> failover_q && hoCnt_q == $past(period_q) ##1 !failover_q;
  endproperty
  a_ho_expire: assert property (p_ho_expire) else $error("no failover");

  property p_ho_idle;
    @(posedge clk) disable iff (!arst_n)
    hoState_q == HRV_HO_IDLE |=> hoCnt_q == $past(period_q);
  endproperty
  a_ho_idle: assert property (p_ho_idle) else $error("idle load wrong");

  property p_fail_cause;
    @(posedge clk) disable iff (!arst_n)
    failover_q |-> $past(tick_q) && $past(hoState_q) == HRV_HO_COUNT
      && $past(hoCnt_q) <= 8'h01;
  endproperty
  a_fail_cause: assert property (p_fail_cause) else $error("stray failover");

  property p_count_write;
    @(posedge clk) disable iff (!arst_n)
    wrCountSel |=> cntSel_q == $past(wrData[1:0]);
  endproperty
  a_count_write: assert property (p_count_write) else $error("count sel write");

endmodule : hrv_holdoff_reval
`default_nettype wire

// ### tb/hrv_ref_model.sv
// Purpose: Two reference inputs seen through their activity monitor
// Assumes: Both inputs share one period of PER clk cycles
// Notes:   Loss is reported once per outage, later dead periods are misses
`timescale 1ns/1ns
`default_nettype none

module hrv_ref_model #(
  parameter int PER = 4
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Control from the bench and flag feedback from the device
  input  wire logic [1:0] alive,
  input  wire logic [1:0] flag,
  // Period events
  output var  logic [1:0] lossEvent,
  output var  logic [1:0] validPeriod,
  output var  logic [1:0] missedPeriod
);
  logic [7:0] phase_q;

  // Shared period timer; one rate keeps the model small
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= 8'h00;
    end else begin
      phase_q <= (phase_q == 8'(PER - 1)) ? 8'h00 : phase_q + 8'h01;
    end
  end

  // One event per input per period; a dead input that is already flagged only misses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lossEvent    <= 2'h0;
      validPeriod  <= 2'h0;
      missedPeriod <= 2'h0;
    end else begin
      lossEvent    <= 2'h0;
      validPeriod  <= 2'h0;
      missedPeriod <= 2'h0;
      if (phase_q == 8'(PER - 1)) begin
        validPeriod  <= alive;
        lossEvent    <= ~alive & ~flag;
        missedPeriod <= ~alive & flag;
      end
    end
  end
endmodule : hrv_ref_model

`default_nettype wire

// ### tb/hrv_holdoff_reval_bench.sv
// Purpose: Self-checking bench for hold-off and revalidation timing
// Assumes: Reference period of 4 clk cycles from the model
// Notes:   Default 2^17 timebase is too slow to time here; 2^15 is timed
`timescale 1ns/1ns
`default_nettype none
`include "hrv_defs.svh"

module hrv_holdoff_reval_bench;
  import hrv_pkg::*;
  logic                              clk;
  logic                              arst_n;
  logic                              wrTb, wrCs, wrPc;
  logic [7:0]                        wrData;
  hrv_tbsel_t                        tbSel;
  hrv_cntsel_t                       csSel;
  logic [7:0]                        pcVal, hoCount;
  logic [1:0]                        lossEv, validP, missP, flag, alive;
  logic [1:0][`HRV_REVAL_W-1:0]      revalCount;
  logic                              tick, active, failover;
  int                                n_errors, cmp_count;

  hrv_holdoff_reval hrv_holdoff_reval_i (.clk(clk), .arst_n(arst_n),
    .wrTimebaseSel(wrTb), .wrCountSel(wrCs), .wrPeriodCount(wrPc),
    .wrData(wrData), .holdoffTimebaseSelect(tbSel),
    .revalidationCountSelect(csSel), .holdoffPeriodCount(pcVal),
    .lossEvent(lossEv), .validPeriod(validP), .missedPeriod(missP),
    .signalLossFlag(flag), .revalCount(revalCount), .holdoffTick(tick),
    .holdoffActive(active), .holdoffCount(hoCount),
    .failoverSwitch(failover));
  hrv_ref_model #(.PER(4)) hrv_ref_model_i (.clk(clk), .arst_n(arst_n),
    .alive(alive), .flag(flag), .lossEvent(lossEv), .validPeriod(validP),
    .missedPeriod(missP));

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One strobed write; sel 0 timebase, 1 count select, 2 period
  task automatic wr(input int sel, input logic [7:0] d);
    @(posedge clk);
    wrTb   <= (sel == 0);
    wrCs   <= (sel == 1);
    wrPc   <= (sel == 2);
    wrData <= d;
    @(posedge clk);
    wrTb <= 1'b0;
    wrCs <= 1'b0;
    wrPc <= 1'b0;
  endtask : wr

  // Kill input 0 and wait past its loss report
  task automatic drop0(input logic [7:0] len);
    int g;
    @(posedge clk);
    alive[0] <= 1'b0;
    for (g = 0; g < 20 && lossEv[0] !== 1'b1; g++) @(negedge clk);
    @(negedge clk);
    chk(flag[0], 1);
    chk(revalCount[0], len);
  endtask : drop0

  // Revive input 0 and count valid periods until its flag clears
  task automatic revive0(input logic [7:0] len, input int stopAt);
    int g;
    int n;
    n = 0;
    @(posedge clk);
    alive[0] <= 1'b1;
    for (g = 0; g < 400 && flag[0] !== 1'b0 && n < stopAt; g++) begin
      @(negedge clk);
      if (validP[0] === 1'b1) n++;
    end
    if (stopAt > 64) begin
      chk(n, len);
      chk(revalCount[0], 0);
    end
  endtask : revive0

  task automatic scen_reval(input logic [1:0] code, input logic [7:0] len);
    wr(1, {6'h00, code});
    #1 chk(csSel, code);
    drop0(len);
    revive0(len, 999);
  endtask : scen_reval

  // Miss after five valid periods must restart the full count
  task automatic scen_miss;
    int g;
    wr(1, 8'h01);
    drop0(8'h10);
    revive0(8'h10, 5);
    @(posedge clk);
    alive[0] <= 1'b0;
    for (g = 0; g < 20 && missP[0] !== 1'b1; g++) @(negedge clk);
    @(negedge clk);
    chk(revalCount[0], 16);
    revive0(8'h10, 999);
  endtask : scen_miss

  // Period 2 at 2^15: failover on the second tick after the loss
  task automatic scen_holdoff;
    int g;
    wr(0, 8'h00);
    wr(2, 8'h02);
    #1 chk(tbSel, 0);
    chk(pcVal, 2);
    @(posedge clk);
    alive[1] <= 1'b0;
    for (g = 0; g < 20 && lossEv[1] !== 1'b1; g++) @(negedge clk);
    @(negedge clk);
    chk({flag[1], active, hoCount}, {2'b11, 8'h02});
    for (g = 0; g < 40000 && tick !== 1'b1; g++) @(negedge clk);
    @(negedge clk);
    chk({tick, hoCount}, {1'b0, 8'h01});
    for (g = 1; g < 40000 && tick !== 1'b1; g++) @(negedge clk);
    chk(g, 32768);
    @(negedge clk);
    chk({failover, hoCount}, {1'b1, 8'h02});
    @(negedge clk);
    chk(failover, 0);
    wr(1, 8'h00);
    @(posedge clk);
    alive[1] <= 1'b1;
    for (g = 0; g < 400 && flag[1] !== 1'b0; g++) @(negedge clk);
    @(negedge clk);
    chk(flag, 0);
    chk(active, 0);
  endtask : scen_holdoff

  // Reset values of settings and status, one cycle after release
  task automatic chk_defaults;
    @(posedge clk);
    #1 chk({tbSel, csSel, pcVal}, {4'ha, 8'h80});
    chk(flag, 0);
    chk({revalCount, tick, active, failover}, 17'h0);
    chk(hoCount, 8'h80);
  endtask : chk_defaults

  // Remaining codes read back, then a mid-run reset restores defaults
  task automatic scen_reset;
    wr(0, 8'h01);
    wr(1, 8'h03);
    #1 chk({tbSel, csSel}, 4'h7);
    wr(0, 8'h03);
    wr(2, 8'h00);
    #1 chk({tbSel, pcVal}, 10'h300);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    chk_defaults();
  endtask : scen_reset

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // Watchdog sized for two 2^15 tick spans plus margin, 85000 cycles
  initial begin
    #680000;
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    arst_n = 1'b0;
    {wrTb, wrCs, wrPc} = 3'h0;
    wrData = 8'h00;
    alive  = 2'h3;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    chk_defaults();
    scen_reval(2'h0, 8'h02);
    scen_reval(2'h1, 8'h10);
    scen_reval(2'h2, 8'h20);
    scen_reval(2'h3, 8'h40);
    scen_miss();
    scen_holdoff();
    scen_reset();
    give_verdict();
  end
endmodule : hrv_holdoff_reval_bench

`default_nettype wire
